/* File: hdl/pats_conv.sv */
// One list-based converter sequencer with result store.
`timescale 1ns/1ps
`default_nettype none
module pats_conv (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic trigger_i,
   input wire logic [1:0] flow_cfg_i,
   input wire logic store_abort_i,
   input wire logic [2:0] resolution_i,
   input wire logic justify_i,
   input wire logic end_of_list_irq_enable_i,
   input wire logic [11:0] sample_i,
   input wire logic cmd_we_i,
   input wire logic [1:0] cmd_idx_i,
   input wire logic [7:0] cmd_data_i,
   output logic res_we_o,
   output logic [pats_pkg::RES_AW-1:0] res_idx_o,
   output logic [15:0] res_data_o,
   output logic eol_irq_o,
   output logic busy_o
);
   logic [7:0] cmd_mem [4];
   pats_pkg::pats_cv_t st_reg;
   logic [1:0] ptr_reg;
   logic [7:0] cmd_reg;
   logic [3:0] cnt_reg;
   logic [pats_pkg::RES_AW-1:0] slot_reg;

   function automatic logic [15:0] fmt(input logic [11:0] s, input logic [2:0] res, input logic rj);
      logic [11:0] v;
      v = (res == pats_pkg::RES_12BIT) ? s : {s[11:4], 4'h0};
      fmt = rj ? {4'h0, v} : {v, 4'h0};
   endfunction

   assign busy_o = (st_reg == pats_pkg::CV_CONV);

   always_ff @(posedge clock_i)
   begin
      if (cmd_we_i)
      begin
         cmd_mem[cmd_idx_i] <= cmd_data_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg <= pats_pkg::CV_IDLE;
         ptr_reg <= 2'h0;
         cmd_reg <= 8'h00;
         cnt_reg <= 4'h0;
         slot_reg <= '0;
         res_we_o <= 1'b0;
         res_idx_o <= '0;
         res_data_o <= 16'h0000;
         eol_irq_o <= 1'b0;
      end
      else
      begin
         res_we_o <= 1'b0;
         eol_irq_o <= 1'b0;
         if (restart_i)
         begin
            ptr_reg <= 2'h0;
            cmd_reg <= cmd_mem[0];
            st_reg <= pats_pkg::CV_READY;
            slot_reg <= '0;
            if (busy_o && store_abort_i)
            begin
               res_we_o <= 1'b1;
               res_idx_o <= slot_reg;
               res_data_o <= fmt(sample_i, resolution_i, justify_i);
            end
         end
         else
         begin
            case (st_reg)
               pats_pkg::CV_READY:
               begin
                  if (trigger_i && flow_cfg_i == pats_pkg::ACC_TRIGGERED)
                  begin
                     st_reg <= pats_pkg::CV_CONV;
                     cnt_reg <= pats_pkg::CONV_CYCLES;
                  end
               end
               pats_pkg::CV_CONV:
               begin
                  if (cnt_reg > 4'h1)
                  begin
                     cnt_reg <= cnt_reg - 4'h1;
                  end
                  else
                  begin
                     res_we_o <= 1'b1;
                     res_data_o <= fmt(sample_i, resolution_i, justify_i);
                     res_idx_o <= slot_reg;
                     slot_reg <= slot_reg + 1'b1;
                     if (cmd_reg[pats_pkg::CMD_EOL])
                     begin
                        eol_irq_o <= end_of_list_irq_enable_i;
                        st_reg <= pats_pkg::CV_IDLE;
                     end
                     else
                     begin
                        ptr_reg <= ptr_reg + 2'h1;
                        cmd_reg <= cmd_mem[ptr_reg + 2'h1];
                        cnt_reg <= pats_pkg::CONV_CYCLES;
                        st_reg <= cmd_reg[pats_pkg::CMD_EOS] ? pats_pkg::CV_READY : pats_pkg::CV_CONV;
                     end
                  end
               end
               pats_pkg::CV_IDLE:
               begin
                  st_reg <= pats_pkg::CV_IDLE;
               end
               default:
               begin
                  st_reg <= pats_pkg::CV_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/pats_sync_top.sv */
// Control-loop synchronisation: modulator, trigger unit, two converters.
//
// Function
// - With the unit enabled, each modulator reload resets and restarts the trigger time-base counter.
// - With the unit enabled, reload is forwarded at once as cycle start.
// - Reload fetches first trigger time and first converter command.
// - Counter equal to trigger value fires a trigger.
// - Equal trigger values fire both converters in the same cycle.
// - A trigger starts the converter's prefetched command sequence.
// - Two independently enabled generators; generator 0 feeds converter 0, 1 feeds 1.
// - Reload issues on every (field plus one)th PWM opportunity.
// - First trigger samples phase currents, second temperature and bus voltage.
// - Converters store results into a result queue without the processor.
// - Duty values are double-buffered and applied at reload with load-ok.
// - The trigger unit drives load-ok once software has finished updating.
// - Modulator honours global load-ok only when its enable bit is one.
// - Center-aligned PWM with edge bit zero; modulus 2500 gives 20 kHz.
// - Complementary leg outputs are separated by a programmable dead time.
// - Generator A is master and makes reload when source field is one.
// - Modulator runs at twice the bus clock; the rest on bus clock.
// - Lists are located by indices relative to a 24-bit three-byte base.
// - Resolution four with justify zero stores 12-bit left-justified results.
// - With store-on-abort set, an interrupted conversion is still stored.
// - Conversion flow follows internal triggers when access field is three.
// - Converter 1 raises end-of-list interrupt when its enable is one.
`timescale 1ns/1ps
`default_nettype none
module pats_sync_top (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [11:0] sample0_i,
   input wire logic [11:0] sample1_i,
   output logic [2:0] pwm_high_o,
   output logic [2:0] pwm_low_o,
   output logic pwm_reload_o,
   output logic cycle_start_o,
   output logic trig0_o,
   output logic trig1_o,
   output logic load_ok_o,
   output logic eol_irq_o
);
   logic [3:0] ctrl_reg;
   logic [7:0] cfg_reg;
   logic [15:0] mod_reg;
   logic [15:0] dt_reg;
   logic [15:0] duty_buf_reg [3];
   logic [15:0] duty_act_reg [3];
   logic [23:0] base_reg;
   logic [31:0] index_reg;
   logic [7:0] adc_cfg_reg;
   logic [15:0] list_mem [32];
   logic [15:0] res_mem [2][8];
   logic [15:0] cnt_reg;
   logic dir_down_reg;
   logic [3:0] fq_cnt_reg;
   logic reload_next;
   logic opp_next;
   logic [15:0] cnt_next;
   logic dir_next;
   logic [2:0] raw_q_reg;
   logic [15:0] dt_cnt_reg [3];
   logic [15:0] tb_reg;
   logic unit_restart;
   logic [pats_pkg::LIST_AW-1:0] base_word;
   logic [pats_pkg::LIST_AW-1:0] g0_addr;
   logic [pats_pkg::LIST_AW-1:0] g1_addr;
   logic g0_done;
   logic g1_done;
   logic c0_we;
   logic c1_we;
   logic [pats_pkg::RES_AW-1:0] c0_idx;
   logic [pats_pkg::RES_AW-1:0] c1_idx;
   logic [15:0] c0_data;
   logic [15:0] c1_data;
   logic c0_busy;
   logic c1_busy;
   logic c0_eol;
   logic cmd_we0;
   logic cmd_we1;

   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic w);
      wr_hit = w && (a == target);
   endfunction

   function automatic logic [15:0] dec_sat(input logic [15:0] v);
      dec_sat = (v > pats_pkg::TICK_STEP) ? v - pats_pkg::TICK_STEP : 16'h0000;
   endfunction

   // Modulator counter in core-clock ticks, two ticks per bus cycle.
   always_comb
   begin
      cnt_next = cnt_reg + pats_pkg::TICK_STEP;
      dir_next = dir_down_reg;
      opp_next = 1'b0;
      if (cfg_reg[pats_pkg::CFG_EDGE])
      begin
         if (cnt_next >= mod_reg)
         begin
            cnt_next = 16'h0000;
            opp_next = 1'b1;
         end
      end
      else if (!dir_down_reg)
      begin
         if (cnt_next >= mod_reg)
         begin
            cnt_next = mod_reg;
            dir_next = 1'b1;
         end
      end
      else
      begin
         cnt_next = dec_sat(cnt_reg);
         if (cnt_next == 16'h0000)
         begin
            dir_next = 1'b0;
            opp_next = 1'b1;
         end
      end
      reload_next = opp_next && (fq_cnt_reg == cfg_reg[pats_pkg::CFG_FQ_LO +: 4]) &&
                    (cfg_reg[pats_pkg::CFG_SRC_LO +: 2] == pats_pkg::SRC_GEN_A);
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= 16'h0000;
         dir_down_reg <= 1'b0;
         fq_cnt_reg <= 4'h0;
         pwm_reload_o <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         dir_down_reg <= dir_next;
         pwm_reload_o <= reload_next;
         if (opp_next)
         begin
            fq_cnt_reg <= (fq_cnt_reg == cfg_reg[pats_pkg::CFG_FQ_LO +: 4]) ? 4'h0 : fq_cnt_reg + 4'h1;
         end
      end
   end

   // Buffered duty values move to the active set at a reload with load-ok.
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 3; i++)
         begin
            duty_act_reg[i] <= 16'h0000;
         end
      end
      else if (reload_next && load_ok_o && cfg_reg[pats_pkg::CFG_GLOAD_EN])
      begin
         for (int i = 0; i < 3; i++)
         begin
            duty_act_reg[i] <= duty_buf_reg[i];
         end
      end
   end

   // Load-ok is set by software and dropped once a reload has consumed it.
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         load_ok_o <= 1'b0;
      end
      else if (wr_hit(addr_i, pats_pkg::A_CTRL, wr_i) && wdata_i[pats_pkg::CTRL_LOAD_OK])
      begin
         load_ok_o <= 1'b1;
      end
      else if (reload_next && cfg_reg[pats_pkg::CFG_GLOAD_EN])
      begin
         load_ok_o <= 1'b0;
      end
   end

   // Three legs share the master counter; each gets its own dead-time gap.
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         raw_q_reg <= 3'h0;
         pwm_high_o <= 3'h0;
         pwm_low_o <= 3'h0;
         for (int i = 0; i < 3; i++)
         begin
            dt_cnt_reg[i] <= 16'h0000;
         end
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if ((cnt_reg < duty_act_reg[i]) != raw_q_reg[i])
            begin
               raw_q_reg[i] <= ~raw_q_reg[i];
               dt_cnt_reg[i] <= dt_reg;
               pwm_high_o[i] <= 1'b0;
               pwm_low_o[i] <= 1'b0;
            end
            else if (dt_cnt_reg[i] != 16'h0000)
            begin
               dt_cnt_reg[i] <= dec_sat(dt_cnt_reg[i]);
               pwm_high_o[i] <= 1'b0;
               pwm_low_o[i] <= 1'b0;
            end
            else
            begin
               pwm_high_o[i] <= raw_q_reg[i];
               pwm_low_o[i] <= ~raw_q_reg[i];
            end
         end
      end
   end

   // Trigger unit: time base and forwarded cycle start.
   assign unit_restart = pwm_reload_o && ctrl_reg[pats_pkg::CTRL_UNIT_EN];
   assign base_word = pats_pkg::LIST_AW'(base_reg >> 1);

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tb_reg <= 16'h0000;
         cycle_start_o <= 1'b0;
      end
      else
      begin
         cycle_start_o <= reload_next && ctrl_reg[pats_pkg::CTRL_UNIT_EN];
         if (unit_restart)
         begin
            tb_reg <= 16'h0000;
         end
         else if (tb_reg != 16'hffff)
         begin
            tb_reg <= tb_reg + 16'h0001;
         end
      end
   end

   // Both generators see one time base, so equal entries fire together.
   pats_trig_gen u_gen0 (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .enable_i(ctrl_reg[pats_pkg::CTRL_UNIT_EN] && ctrl_reg[pats_pkg::CTRL_GEN0_EN]),
      .restart_i(unit_restart),
      .count_i(tb_reg),
      .base_i(base_word),
      .primary_i(index_reg[7:0]),
      .alternate_i(index_reg[15:8]),
      .data_i(list_mem[g0_addr]),
      .addr_o(g0_addr),
      .trig_o(trig0_o),
      .done_o(g0_done)
   );

   pats_trig_gen u_gen1 (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .enable_i(ctrl_reg[pats_pkg::CTRL_UNIT_EN] && ctrl_reg[pats_pkg::CTRL_GEN1_EN]),
      .restart_i(unit_restart),
      .count_i(tb_reg),
      .base_i(base_word),
      .primary_i(index_reg[23:16]),
      .alternate_i(index_reg[31:24]),
      .data_i(list_mem[g1_addr]),
      .addr_o(g1_addr),
      .trig_o(trig1_o),
      .done_o(g1_done)
   );

   assign cmd_we0 = wr_hit(addr_i, pats_pkg::A_CMD_WR, wr_i) && !wdata_i[pats_pkg::CMD_SEL];
   assign cmd_we1 = wr_hit(addr_i, pats_pkg::A_CMD_WR, wr_i) && wdata_i[pats_pkg::CMD_SEL];

   // Converter 0 samples phase A and bus voltage, converter 1 phase B and temperature.
   pats_conv u_conv0 (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .restart_i(cycle_start_o),
      .trigger_i(trig0_o),
      .flow_cfg_i(adc_cfg_reg[5:4]),
      .store_abort_i(adc_cfg_reg[6]),
      .resolution_i(adc_cfg_reg[2:0]),
      .justify_i(adc_cfg_reg[3]),
      .end_of_list_irq_enable_i(1'b0),
      .sample_i(sample0_i),
      .cmd_we_i(cmd_we0),
      .cmd_idx_i(wdata_i[9:8]),
      .cmd_data_i(wdata_i[7:0]),
      .res_we_o(c0_we),
      .res_idx_o(c0_idx),
      .res_data_o(c0_data),
      .eol_irq_o(c0_eol),
      .busy_o(c0_busy)
   );

   pats_conv u_conv1 (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .restart_i(cycle_start_o),
      .trigger_i(trig1_o),
      .flow_cfg_i(adc_cfg_reg[5:4]),
      .store_abort_i(adc_cfg_reg[6]),
      .resolution_i(adc_cfg_reg[2:0]),
      .justify_i(adc_cfg_reg[3]),
      .end_of_list_irq_enable_i(adc_cfg_reg[7]),
      .sample_i(sample1_i),
      .cmd_we_i(cmd_we1),
      .cmd_idx_i(wdata_i[9:8]),
      .cmd_data_i(wdata_i[7:0]),
      .res_we_o(c1_we),
      .res_idx_o(c1_idx),
      .res_data_o(c1_data),
      .eol_irq_o(eol_irq_o),
      .busy_o(c1_busy)
   );

   // Result queues and trigger list live in local memory.
   always_ff @(posedge clock_i)
   begin
      if (c0_we)
      begin
         res_mem[0][c0_idx] <= c0_data;
      end
      if (c1_we)
      begin
         res_mem[1][c1_idx] <= c1_data;
      end
      if (wr_hit(addr_i, pats_pkg::A_LIST_WR, wr_i))
      begin
         list_mem[wdata_i[20:16]] <= wdata_i[15:0];
      end
   end

   // Software writable configuration.
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= 4'h0;
         cfg_reg <= {pats_pkg::FQ_RST, 1'b0, pats_pkg::SRC_GEN_A, 1'b0};
         mod_reg <= pats_pkg::MOD_RST;
         dt_reg <= pats_pkg::DT_RST;
         base_reg <= 24'h000000;
         index_reg <= 32'h00000000;
         adc_cfg_reg <= {2'h0, pats_pkg::ACC_TRIGGERED, 1'b0, pats_pkg::RES_12BIT};
         for (int i = 0; i < 3; i++)
         begin
            duty_buf_reg[i] <= 16'h0000;
         end
      end
      else if (wr_i)
      begin
         case (addr_i)
            pats_pkg::A_CTRL: ctrl_reg <= {1'b0, wdata_i[2:0]};
            pats_pkg::A_PWM_CFG: cfg_reg <= wdata_i[7:0];
            pats_pkg::A_MODULUS: mod_reg <= wdata_i[15:0];
            pats_pkg::A_DEADTIME: dt_reg <= wdata_i[15:0];
            pats_pkg::A_DUTY_A: duty_buf_reg[0] <= wdata_i[15:0];
            pats_pkg::A_DUTY_B: duty_buf_reg[1] <= wdata_i[15:0];
            pats_pkg::A_DUTY_C: duty_buf_reg[2] <= wdata_i[15:0];
            pats_pkg::A_BASE_LOW: base_reg[7:0] <= wdata_i[7:0];
            pats_pkg::A_BASE_MID: base_reg[15:8] <= wdata_i[7:0];
            pats_pkg::A_BASE_HIGH: base_reg[23:16] <= wdata_i[7:0];
            pats_pkg::A_INDEX: index_reg <= wdata_i;
            pats_pkg::A_ADC_CFG: adc_cfg_reg <= wdata_i[7:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 32'h00000000;
      end
      else if (!rd_i)
      begin
         rdata_o <= 32'h00000000;
      end
      else if (addr_i[7:6] == 2'b01)
      begin
         rdata_o <= {16'h0000, res_mem[addr_i[5]][addr_i[4:2]]};
      end
      else
      begin
         case (addr_i)
            pats_pkg::A_CTRL: rdata_o <= {28'h0, load_ok_o, ctrl_reg[2:0]};
            pats_pkg::A_PWM_CFG: rdata_o <= {24'h0, cfg_reg};
            pats_pkg::A_MODULUS: rdata_o <= {16'h0, mod_reg};
            pats_pkg::A_DEADTIME: rdata_o <= {16'h0, dt_reg};
            pats_pkg::A_DUTY_A: rdata_o <= {16'h0, duty_buf_reg[0]};
            pats_pkg::A_DUTY_B: rdata_o <= {16'h0, duty_buf_reg[1]};
            pats_pkg::A_DUTY_C: rdata_o <= {16'h0, duty_buf_reg[2]};
            pats_pkg::A_BASE_LOW: rdata_o <= {24'h0, base_reg[7:0]};
            pats_pkg::A_BASE_MID: rdata_o <= {24'h0, base_reg[15:8]};
            pats_pkg::A_BASE_HIGH: rdata_o <= {24'h0, base_reg[23:16]};
            pats_pkg::A_INDEX: rdata_o <= index_reg;
            pats_pkg::A_ADC_CFG: rdata_o <= {24'h0, adc_cfg_reg};
            pats_pkg::A_STATUS: rdata_o <= {10'h0, c0_eol, c1_busy, c0_busy, g1_done, g0_done, dir_down_reg, tb_reg};
            default: rdata_o <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: hdl/pats_trig_gen.sv */
// One trigger generator walking its trigger-time list.
`timescale 1ns/1ps
`default_nettype none
module pats_trig_gen (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic restart_i,
   input wire logic [15:0] count_i,
   input wire logic [pats_pkg::LIST_AW-1:0] base_i,
   input wire logic [7:0] primary_i,
   input wire logic [7:0] alternate_i,
   input wire logic [15:0] data_i,
   output logic [pats_pkg::LIST_AW-1:0] addr_o,
   output logic trig_o,
   output logic done_o
);
   pats_pkg::pats_tg_t st_reg;
   logic alt_reg;
   logic [15:0] val_reg;

   assign done_o = (st_reg == pats_pkg::TG_DONE);

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg <= pats_pkg::TG_IDLE;
         alt_reg <= 1'b0;
         val_reg <= 16'h0000;
         addr_o <= '0;
         trig_o <= 1'b0;
      end
      else
      begin
         trig_o <= 1'b0;
         if (!enable_i)
         begin
            st_reg <= pats_pkg::TG_IDLE;
         end
         else if (restart_i)
         begin
            // Primary and alternate lists are used on alternate cycles.
            st_reg <= pats_pkg::TG_LOAD;
            addr_o <= pats_pkg::LIST_AW'(base_i + (alt_reg ? alternate_i : primary_i));
            alt_reg <= ~alt_reg;
         end
         else
         begin
            case (st_reg)
               pats_pkg::TG_LOAD:
               begin
                  if (data_i == 16'h0000)
                  begin
                     st_reg <= pats_pkg::TG_DONE;
                  end
                  else
                  begin
                     val_reg <= data_i;
                     st_reg <= pats_pkg::TG_ARMED;
                  end
               end
               pats_pkg::TG_ARMED:
               begin
                  if (count_i == val_reg)
                  begin
                     trig_o <= 1'b1;
                     addr_o <= addr_o + 1'b1;
                     st_reg <= pats_pkg::TG_LOAD;
                  end
               end
               pats_pkg::TG_IDLE, pats_pkg::TG_DONE:
               begin
                  st_reg <= st_reg;
               end
               default:
               begin
                  st_reg <= pats_pkg::TG_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: pkg/pats_pkg.sv */
// Constants shared by the control-loop synchronisation block.
package pats_pkg;
   localparam int unsigned BUS_HZ = 50_000_000;
   localparam int unsigned CORE_HZ = 100_000_000;
   localparam logic [15:0] TICK_STEP = 16'(CORE_HZ / BUS_HZ);
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PWM_CFG = 8'h04;
   localparam logic [7:0] A_MODULUS = 8'h08;
   localparam logic [7:0] A_DEADTIME = 8'h0c;
   localparam logic [7:0] A_DUTY_A = 8'h10;
   localparam logic [7:0] A_DUTY_B = 8'h14;
   localparam logic [7:0] A_DUTY_C = 8'h18;
   localparam logic [7:0] A_BASE_LOW = 8'h1c;
   localparam logic [7:0] A_BASE_MID = 8'h20;
   localparam logic [7:0] A_BASE_HIGH = 8'h24;
   localparam logic [7:0] A_INDEX = 8'h28;
   localparam logic [7:0] A_ADC_CFG = 8'h2c;
   localparam logic [7:0] A_LIST_WR = 8'h30;
   localparam logic [7:0] A_CMD_WR = 8'h34;
   localparam logic [7:0] A_STATUS = 8'h38;
   localparam logic [7:0] A_RESULT = 8'h40;
   localparam int CTRL_UNIT_EN = 0;
   localparam int CTRL_GEN0_EN = 1;
   localparam int CTRL_GEN1_EN = 2;
   localparam int CTRL_LOAD_OK = 3;
   localparam int CFG_EDGE = 0;
   localparam int CFG_SRC_LO = 1;
   localparam int CFG_GLOAD_EN = 3;
   localparam int CFG_FQ_LO = 4;
   localparam int CMD_SEL = 12;
   localparam logic [15:0] MOD_RST = 16'h09c4;
   localparam logic [15:0] DT_RST = 16'h0019;
   localparam logic [3:0] FQ_RST = 4'h3;
   localparam logic [1:0] SRC_GEN_A = 2'h1;
   localparam logic [1:0] ACC_TRIGGERED = 2'h3;
   localparam logic [2:0] RES_12BIT = 3'h4;
   localparam logic [3:0] CONV_CYCLES = 4'he;
   localparam int CMD_EOL = 7;
   localparam int CMD_EOS = 6;
   localparam int LIST_AW = 5;
   localparam int RES_AW = 3;
   typedef enum logic [1:0] {TG_IDLE = 2'b00, TG_LOAD = 2'b01, TG_ARMED = 2'b11, TG_DONE = 2'b10} pats_tg_t;
   typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_READY = 2'b01, CV_CONV = 2'b11} pats_cv_t;
endpackage

/* File: tb/pats_far_model.sv */
// Far-side model: the values the two converters sample.
`timescale 1ns/1ps
`default_nettype none
module pats_far_model (
   output logic [11:0] sample0_o,
   output logic [11:0] sample1_o
);
   assign sample0_o = 12'h123;
   assign sample1_o = 12'habc;
endmodule
`default_nettype wire

/* File: tb/pats_sync_chk.sv */
// Port timing checker of the synchronisation block.
`timescale 1ns/1ps
`default_nettype none
module pats_sync_chk (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [2:0] pwm_high_o,
   input wire logic [2:0] pwm_low_o,
   input wire logic pwm_reload_o,
   input wire logic cycle_start_o,
   input wire logic trig0_o,
   input wire logic trig1_o,
   input wire logic load_ok_o,
   input wire logic eol_irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence quiet_s;
      (!trig0_o && !trig1_o) [*2];
   endsequence
   AST_FWD: assert property (cycle_start_o |-> pwm_reload_o) else $error("lone cycle start");
   AST_QUIET: assert property (pwm_reload_o |=> quiet_s) else $error("early trigger");
   AST_RLD: assert property (pwm_reload_o |=> !pwm_reload_o) else $error("long reload");
   AST_T0: assert property (trig0_o |=> !trig0_o) else $error("long trigger");
   AST_DT: assert property (!(|(pwm_high_o & pwm_low_o))) else $error("leg overlap");
   AST_DTG: assert property ($fell(pwm_high_o[0]) |-> !pwm_low_o[0]) else $error("no dead time");
   AST_LOAD_OK_SIGNAL: assert property ($fell(load_ok_o) |-> pwm_reload_o) else $error("load-ok lost");
   AST_EOL: assert property (eol_irq_o |=> !eol_irq_o) else $error("long end of list");
endmodule
bind pats_sync_top pats_sync_chk u_chk (.clock_i, .rst_i, .pwm_high_o, .pwm_low_o, .pwm_reload_o,
   .cycle_start_o, .trig0_o, .trig1_o, .load_ok_o, .eol_irq_o);
`default_nettype wire

/* File: tb/tb_pwm_adc_trigger_sync.sv */
// Self-checking bench of the control-loop synchronisation block.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_adc_trigger_sync;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [11:0] s0;
   logic [11:0] s1;
   logic [2:0] hi;
   logic [2:0] lo;
   logic rl, cs, t0, t1, lok, eol;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   int n;
   int t;
   logic [31:0] rd;
   logic [7:0] row_a [6] = '{pats_pkg::A_PWM_CFG, pats_pkg::A_MODULUS, pats_pkg::A_DEADTIME,
      pats_pkg::A_ADC_CFG, pats_pkg::A_CTRL, 8'hfc};
   logic [31:0] row_e [6] = '{32'h32, 32'h9c4, 32'h19, 32'h34, 32'h0, 32'h0};
   pats_sync_top dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .sample0_i(s0), .sample1_i(s1), .pwm_high_o(hi), .pwm_low_o(lo),
      .pwm_reload_o(rl), .cycle_start_o(cs), .trig0_o(t0), .trig1_o(t1), .load_ok_o(lok), .eol_irq_o(eol));
   pats_far_model u_far (.sample0_o(s0), .sample1_o(s1));
   always #10 clock_i = ~clock_i;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      d = rdata_o;
   endtask
   task automatic upto(ref logic s, output int k);
      k = 0;
      do
      begin
         @(negedge clock_i);
         k++;
      end
      while (s !== 1'b1 && k < 1000);
      if (s !== 1'b1)
      begin
         fails++;
         $display("CHECK FAILED wait expected 1 seen 0");
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         end_sim();
      end
   end
   initial
   begin
      repeat (5) @(posedge clock_i);
      @(negedge clock_i);
      chk("reset", 32'h0, {rdata_o[16:0], hi, lo, rl, cs, t0, t1, lok, eol});
      @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         rdr(row_a[i], rd);
         chk("register", row_e[i], rd);
      end
      wr(pats_pkg::A_MODULUS, 32'd100);
      wr(pats_pkg::A_LIST_WR, 32'h0000000a);
      wr(pats_pkg::A_LIST_WR, 32'h00010014);
      wr(pats_pkg::A_LIST_WR, 32'h00020000);
      wr(pats_pkg::A_CMD_WR, 32'h000000c0);
      wr(pats_pkg::A_CMD_WR, 32'h000010c0);
      wr(pats_pkg::A_ADC_CFG, 32'hb4);
      wr(pats_pkg::A_PWM_CFG, 32'h0a);
      wr(pats_pkg::A_DUTY_A, 32'h50);
      wr(pats_pkg::A_CTRL, 32'h0f);
      @(negedge clock_i);
      chk("load ok", 1, lok);
      upto(rl, n);
      chk("cycle start", 1, cs);
      upto(t0, t);
      chk("lag", 1, t inside {11, 12});
      chk("both triggers", 1, t1);
      chk("load ok clear", 0, lok);
      upto(t0, t);
      chk("next trigger", 10, t);
      chk("duty applied", 32'h0e, {hi, lo});
      upto(eol, t);
      chk("end of list", 1, t < 40);
      rdr(pats_pkg::A_RESULT, rd);
      chk("result 0", 32'h1230, rd);
      rdr(8'h60, rd);
      chk("result 1", 32'habc0, rd);
      upto(rl, n);
      upto(rl, n);
      wr(pats_pkg::A_PWM_CFG, 32'h3a);
      upto(rl, t);
      upto(rl, t);
      chk("reload spacing", 4 * n, t);
      wr(pats_pkg::A_CTRL, 32'h03);
      upto(t0, t);
      chk("gen1 off", 0, t1);
      end_sim();
   end
endmodule
`default_nettype wire
